// ==== verilog/txrxf_regs.vh ====
// Constants for the transmit/receive frame FIFO subsystem
`ifndef TXRXF_REGS_VH
`define TXRXF_REGS_VH
`define TXRXF_BUF_BYTES      12'hc00
`define TXRXF_BUF_AW         10
`define TXRXF_WORDS          10'h300
`define TXRXF_MIN_FRAME      12'h040
`define TXRXF_SYNC_BYTES     12'h080
`define TXRXF_IFG_NS         960
`define TXRXF_CLK_NS         10
`define TXRXF_IFG_CYC        ((`TXRXF_IFG_NS + `TXRXF_CLK_NS - 1) / `TXRXF_CLK_NS)
`define TXRXF_THR_RESET      12'h200
`endif

// ==== verilog/txrxf_top.v ====
// Frame FIFO subsystem: transmit and receive frame buffers with early release
`timescale 1ns/100ps
`include "txrxf_regs.vh"
// What this block does
// - Separate 3 KB transmit and receive buffers
// - One frame staged at a time; interframe gap after each frame
// - Programmable fill threshold before transmit starts
// - Bus side waits while buffer full or a finished frame is staged
// - Collision or underrun replays frame from buffer
// - Received runt frames dropped before host
// - High and low priority transmit queues
// - Pointer read returns next high-priority command address
// - Pointer read freezes high-priority command fetches beyond it
// - Early release only when enabled
// - Only head-of-queue frame qualifies
// - Only fully written, checksum-processed frames qualify
// - Frames over 3 KB never released early
// - Over 128 bytes passed to sync buffer
// - Early release raises bus side free count; fill still waits for transmit ok
module txrxf_top #(
    parameter AW = `TXRXF_BUF_AW,
    parameter DW = 32
) (
    // Clock and reset
    input  wire          core_clk_in,
    input  wire          resetn_in,
    // Configuration
    input  wire          early_release_en_in,
    input  wire [11:0]   tx_threshold_in,
    input  wire          preemptive_queue_in,
    // Command queues from bus engine
    input  wire [31:0]   hp_cmd_addr_in,
    input  wire          hp_cmd_valid_in,
    input  wire [31:0]   lp_cmd_addr_in,
    input  wire          lp_cmd_valid_in,
    input  wire          cmd_ptr_rd_in,
    output reg  [31:0]   cmd_ptr_out,
    output reg           hp_fetch_ok_out,
    output reg           hp_cmd_take_out,
    output reg           lp_cmd_take_out,
    // Transmit fill side (bus engine)
    input  wire [DW-1:0] txf_data_in,
    input  wire          txf_valid_in,
    input  wire          txf_last_in,
    input  wire          txf_csum_done_in,
    output reg           txf_ready_out,
    output reg  [11:0]   tx_free_bytes_out,
    // Transmit drain side (MAC)
    output reg  [DW-1:0] mac_tx_data_out,
    output reg           mac_tx_valid_out,
    output reg           mac_tx_last_out,
    input  wire          mac_tx_ready_in,
    input  wire          mac_collision_in,
    input  wire          mac_underrun_in,
    input  wire          mac_tx_ok_in,
    // Receive fill side (MAC)
    input  wire [DW-1:0] mac_rx_data_in,
    input  wire          mac_rx_valid_in,
    input  wire          mac_rx_last_in,
    // Receive drain side (bus engine)
    output reg  [DW-1:0] rxd_data_out,
    output reg           rxd_valid_out,
    output reg           rxd_last_out,
    input  wire          rxd_ready_in
);
    ////////////////////////////////////////////////////////////////////////////
    // Transmit frame memory
    // Word capacity of each buffer; pointers carry a spare bit so full differs from empty
    localparam [AW:0]  DEPTH   = {1'b0, `TXRXF_WORDS};
    // Gap load trimmed to the counter width on purpose
    localparam integer IFG_I   = `TXRXF_IFG_CYC;
    localparam [7:0]   IFG_CYC = IFG_I[7:0];
    reg [DW-1:0] tx_mem [0:(1<<AW)-1];
    reg [DW:0]   rx_mem [0:(1<<AW)-1];
    reg [AW:0]   tx_wr_r;
    reg [AW:0]   tx_fstart_r;
    reg [AW:0]   tx_rd_r;
    reg [AW:0]   tx_rel_r;
    reg [AW:0]   tx_frame_head_r;
    reg [AW:0]   tx_frame_end_r;
    reg          tx_frame_rdy_r;
    reg          tx_frame_big_r;
    reg [11:0]   tx_frame_bytes_r;
    reg [11:0]   tx_sent_bytes_r;
    reg          tx_released_r;
    reg          tx_active_r;
    reg [7:0]    ifg_cnt_r;
    wire [AW:0]  tx_used = tx_wr_r - tx_rel_r;
    wire         tx_full = (tx_used == DEPTH);
    wire [AW:0]  tx_stage = tx_wr_r - tx_rd_r;
    wire [AW:0]  tx_free_w = DEPTH - tx_used;

    // One frame staged at a time: a finished frame blocks fill until it is gone

    always @* begin
        txf_ready_out = ~tx_full & ~tx_frame_rdy_r;
    end
    wire tx_wr_fire = txf_valid_in & txf_ready_out;

    // Frame memory has no reset, so its writes live outside the reset process
    always @(posedge core_clk_in) begin
        if (tx_wr_fire) begin
            tx_mem[tx_wr_r[AW-1:0]] <= txf_data_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry skid buffer toward the MAC
    reg [DW:0]  sk_d0_r;
    reg [DW:0]  sk_d1_r;
    reg [1:0]   sk_cnt_r;
    reg         sk_vld_r;
    wire        sk_push;
    wire        sk_pop = mac_tx_valid_out & mac_tx_ready_in;
    wire        sk_room = (sk_cnt_r != 2'h2);

    // Threshold compared in words; a complete frame starts regardless of it
    wire start_ok = tx_frame_rdy_r | (tx_stage[AW:0] >= tx_threshold_in[AW+1:2]);
    assign sk_push = tx_active_r & sk_room & (tx_rd_r != tx_wr_r) &
                     ~mac_collision_in & ~mac_underrun_in;
    wire last_word = tx_frame_rdy_r & (tx_rd_r + 1'b1 == tx_frame_end_r);
    wire [DW:0] sk_word = {last_word, tx_mem[tx_rd_r[AW-1:0]]};

    // Two entries so a stalled MAC never loses a word in flight
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sk_d0_r  <= {(DW+1){1'b0}};
            sk_d1_r  <= {(DW+1){1'b0}};
            sk_cnt_r <= 2'h0;
            sk_vld_r <= 1'b0;
        end else begin
            case ({sk_push, sk_pop})
                2'b10: begin
                    if (sk_cnt_r == 2'h0) begin
                        sk_d0_r <= sk_word;
                    end else begin
                        sk_d1_r <= sk_word;
                    end
                    sk_cnt_r <= sk_cnt_r + 2'h1;
                    sk_vld_r <= 1'b1;
                end
                2'b01: begin
                    sk_d0_r  <= sk_d1_r;
                    sk_cnt_r <= sk_cnt_r - 2'h1;
                    sk_vld_r <= (sk_cnt_r != 2'h1);
                end
                2'b11: begin
                    if (sk_cnt_r == 2'h1) begin
                        sk_d0_r <= sk_word;
                    end else begin
                        sk_d0_r <= sk_d1_r;
                        sk_d1_r <= sk_word;
                    end
                end
                default: begin
                    sk_cnt_r <= sk_cnt_r;
                end
            endcase
            // A collision flushes both entries; the replay refills them from the head
            if (mac_collision_in | mac_underrun_in) begin
                sk_cnt_r <= 2'h0;
                sk_vld_r <= 1'b0;
            end
        end
    end

    always @* begin
        mac_tx_valid_out = sk_vld_r;
        mac_tx_data_out  = sk_d0_r[DW-1:0];
        mac_tx_last_out  = sk_d0_r[DW];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit fill and drain control
    // Every condition must hold together; any miss keeps the space until success
    wire er_ok = early_release_en_in & ~tx_released_r & tx_active_r
               & ~preemptive_queue_in
               & tx_frame_rdy_r
               & ~tx_frame_big_r
               & (tx_sent_bytes_r > `TXRXF_SYNC_BYTES);

    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_wr_r          <= {(AW+1){1'b0}};
            tx_fstart_r      <= {(AW+1){1'b0}};
            tx_rd_r          <= {(AW+1){1'b0}};
            tx_rel_r         <= {(AW+1){1'b0}};
            tx_frame_head_r  <= {(AW+1){1'b0}};
            tx_frame_end_r   <= {(AW+1){1'b0}};
            tx_frame_rdy_r   <= 1'b0;
            tx_frame_big_r   <= 1'b0;
            tx_frame_bytes_r <= 12'h000;
            tx_sent_bytes_r  <= 12'h000;
            tx_released_r    <= 1'b0;
            tx_active_r      <= 1'b0;
            ifg_cnt_r        <= 8'h00;
            tx_free_bytes_out <= `TXRXF_BUF_BYTES;
        end else begin
            tx_free_bytes_out <= {tx_free_w[AW-1:0], 2'b00};
            if (tx_wr_fire) begin
                tx_wr_r <= tx_wr_r + 1'b1;
                // Count saturates; an oversized frame only loses early release
                if (tx_frame_bytes_r >= `TXRXF_BUF_BYTES - 12'h004) begin
                    tx_frame_big_r <= 1'b1;
                end else begin
                    tx_frame_bytes_r <= tx_frame_bytes_r + 12'h004;
                end
            end
            // Frame ready only once last word and checksum both done
            if (tx_wr_fire & txf_last_in & txf_csum_done_in) begin
                tx_frame_rdy_r <= 1'b1;
                tx_frame_end_r <= tx_wr_r + 1'b1;
            end
            if (ifg_cnt_r != 8'h00) begin
                ifg_cnt_r <= ifg_cnt_r - 8'h01;
            end
            if (!tx_active_r) begin
                if ((ifg_cnt_r == 8'h00) && (tx_wr_r != tx_frame_head_r) && start_ok) begin
                    tx_active_r     <= 1'b1;
                    tx_sent_bytes_r <= 12'h000;
                end
            end else begin
                if (sk_push) begin
                    tx_rd_r         <= tx_rd_r + 1'b1;
                    tx_sent_bytes_r <= tx_sent_bytes_r + 12'h004;
                end
                if (mac_collision_in | mac_underrun_in) begin
                    tx_rd_r         <= tx_frame_head_r;
                    tx_sent_bytes_r <= 12'h000;
                    tx_active_r     <= 1'b0;
                    ifg_cnt_r       <= IFG_CYC;
                end else if (mac_tx_ok_in) begin
                    tx_active_r      <= 1'b0;
                    tx_released_r    <= 1'b0;
                    tx_rel_r         <= tx_frame_end_r;
                    tx_frame_head_r  <= tx_frame_end_r;
                    tx_frame_rdy_r   <= 1'b0;
                    tx_frame_big_r   <= 1'b0;
                    tx_frame_bytes_r <= 12'h000;
                    ifg_cnt_r        <= IFG_CYC;
                end else if (er_ok) begin
                    // Collision window assumed past; a later collision still replays from the head
                    tx_released_r <= 1'b1;
                    tx_rel_r      <= tx_frame_end_r;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command queues and next-command pointer
    reg ptr_frozen_r;
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cmd_ptr_out     <= 32'h0000_0000;
            ptr_frozen_r    <= 1'b0;
            hp_fetch_ok_out <= 1'b1;
            hp_cmd_take_out <= 1'b0;
            lp_cmd_take_out <= 1'b0;
        end else begin
            cmd_ptr_out <= hp_cmd_addr_in;
            // A fresh offer after the freeze means software has finished rewriting
            if (cmd_ptr_rd_in) begin
                ptr_frozen_r <= 1'b1;
            end else if (hp_cmd_valid_in & ~hp_fetch_ok_out) begin
                ptr_frozen_r <= 1'b0;
            end
            hp_fetch_ok_out <= ~cmd_ptr_rd_in & ~ptr_frozen_r;
            // High priority taken when offered and not frozen; an offered high priority always blocks low priority
            hp_cmd_take_out <= hp_cmd_valid_in & ~cmd_ptr_rd_in & ~ptr_frozen_r;
            lp_cmd_take_out <= lp_cmd_valid_in & ~hp_cmd_valid_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive buffer with runt discard
    reg [AW:0]  rx_wr_r;
    reg [AW:0]  rx_commit_r;
    reg [AW:0]  rx_rd_r;
    reg [11:0]  rx_len_r;
    wire [AW:0] rx_used = rx_wr_r - rx_rd_r;
    wire        rx_pop = rxd_valid_out & rxd_ready_in;
    wire        rx_load = (rx_rd_r != rx_commit_r) & (~rxd_valid_out | rx_pop);
    // No back-pressure toward the MAC: words arriving while full are lost
    wire        rx_wr_fire = mac_rx_valid_in & (rx_used != DEPTH);

    always @(posedge core_clk_in) begin
        if (rx_wr_fire) begin
            rx_mem[rx_wr_r[AW-1:0]] <= {mac_rx_last_in, mac_rx_data_in};
        end
    end

    // Runt frames rewind the write pointer to the last committed frame

    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_wr_r       <= {(AW+1){1'b0}};
            rx_commit_r   <= {(AW+1){1'b0}};
            rx_rd_r       <= {(AW+1){1'b0}};
            rx_len_r      <= 12'h000;
            rxd_data_out  <= {DW{1'b0}};
            rxd_valid_out <= 1'b0;
            rxd_last_out  <= 1'b0;
        end else begin
            if (rx_wr_fire) begin
                if (mac_rx_last_in) begin
                    rx_len_r <= 12'h000;
                    if (rx_len_r + 12'h004 < `TXRXF_MIN_FRAME)
                        rx_wr_r <= rx_commit_r;
                    else begin
                        rx_wr_r     <= rx_wr_r + 1'b1;
                        rx_commit_r <= rx_wr_r + 1'b1;
                    end
                end else begin
                    rx_wr_r  <= rx_wr_r + 1'b1;
                    rx_len_r <= rx_len_r + 12'h004;
                end
            end
            if (rx_load) begin
                rxd_data_out  <= rx_mem[rx_rd_r[AW-1:0]][DW-1:0];
                rxd_last_out  <= rx_mem[rx_rd_r[AW-1:0]][DW];
                rxd_valid_out <= 1'b1;
                rx_rd_r       <= rx_rd_r + 1'b1;
            end else if (rx_pop) begin
                rxd_valid_out <= 1'b0;
            end
        end
    end
endmodule // txrxf_top

// ==== tb/txrxf_properties.sv ====
// Port-level checks for the frame FIFO subsystem
`timescale 1ns/100ps
module txrxf_props #(parameter DW = 32) (
    input wire core_clk_in, input wire resetn_in, input wire early_release_en_in,
    input wire [31:0] hp_cmd_addr_in, input wire cmd_ptr_rd_in, input wire [31:0] cmd_ptr_out,
    input wire hp_fetch_ok_out, input wire hp_cmd_take_out, input wire [11:0] tx_free_bytes_out,
    input wire [DW-1:0] mac_tx_data_out, input wire mac_tx_valid_out, input wire mac_tx_last_out,
    input wire mac_tx_ready_in, input wire mac_collision_in, input wire mac_tx_ok_in,
    input wire [DW-1:0] rxd_data_out, input wire rxd_valid_out, input wire rxd_last_out,
    input wire rxd_ready_in);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    reg  [7:0]  gap_r;
    reg         mid_r;
    reg  [11:0] rxw_r;
    wire        txh = mac_tx_valid_out && mac_tx_ready_in;
    wire        rxh = rxd_valid_out && rxd_ready_in;
    // Gap counted from last word or collision; saturates so idle spans stay legal
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            gap_r <= 8'hff;
            mid_r <= 1'b0;
            rxw_r <= 12'h0;
        end else begin
            gap_r <= ((txh && mac_tx_last_out) || mac_collision_in) ? 8'h0 :
                     (gap_r == 8'hff ? gap_r : gap_r + 8'h1);
            mid_r <= txh ? !mac_tx_last_out : (mac_collision_in ? 1'b0 : mid_r);
            rxw_r <= rxh ? (rxd_last_out ? 12'h0 : rxw_r + 12'h1) : rxw_r;
        end
    end
    ////////////////////////////////////////
    sequence s_tx_stall; mac_tx_valid_out && !mac_tx_ready_in && !mac_collision_in; endsequence
    sequence s_frozen; !hp_fetch_ok_out ##1 !hp_fetch_ok_out; endsequence
    property p_tx_hold; s_tx_stall |=> mac_tx_valid_out && $stable(mac_tx_data_out); endproperty
    property p_rx_hold;
        rxd_valid_out && !rxd_ready_in |=> rxd_valid_out && $stable(rxd_data_out);
    endproperty
    property p_free_max; tx_free_bytes_out <= 12'hc00 && tx_free_bytes_out[1:0] == 2'b00; endproperty
    property p_ptr; cmd_ptr_rd_in |=> cmd_ptr_out == $past(hp_cmd_addr_in); endproperty
    property p_freeze; s_frozen |-> !hp_cmd_take_out; endproperty
    property p_release;
        tx_free_bytes_out > $past(tx_free_bytes_out) |-> $past(mac_tx_ok_in) ||
            $past(mac_tx_ok_in, 2) || $past(mac_tx_ok_in, 3) || $past(early_release_en_in);
    endproperty
    property p_rx_len; rxh && rxd_last_out |-> rxw_r >= 12'd15; endproperty
    property p_gap; $rose(mac_tx_valid_out) && !mid_r |-> gap_r >= 8'd96; endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx word lost in stall");
    a_rx_hold: assert property (p_rx_hold) else $error("rx word lost in stall");
    a_free_max: assert property (p_free_max) else $error("free count out of range");
    a_ptr: assert property (p_ptr) else $error("pointer value wrong");
    a_freeze: assert property (p_freeze) else $error("fetch while frozen");
    a_release: assert property (p_release) else $error("space freed without cause");
    a_rx_len: assert property (p_rx_len) else $error("short frame delivered");
    a_gap: assert property (p_gap) else $error("interframe gap too short");
endmodule // txrxf_props
bind txrxf_top txrxf_props #(.DW(DW)) txrxf_props_inst (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .early_release_en_in(early_release_en_in),
    .hp_cmd_addr_in(hp_cmd_addr_in), .cmd_ptr_rd_in(cmd_ptr_rd_in), .cmd_ptr_out(cmd_ptr_out),
    .hp_fetch_ok_out(hp_fetch_ok_out), .hp_cmd_take_out(hp_cmd_take_out),
    .tx_free_bytes_out(tx_free_bytes_out), .mac_tx_data_out(mac_tx_data_out),
    .mac_tx_valid_out(mac_tx_valid_out), .mac_tx_last_out(mac_tx_last_out),
    .mac_tx_ready_in(mac_tx_ready_in), .mac_collision_in(mac_collision_in),
    .mac_tx_ok_in(mac_tx_ok_in), .rxd_data_out(rxd_data_out), .rxd_valid_out(rxd_valid_out),
    .rxd_last_out(rxd_last_out), .rxd_ready_in(rxd_ready_in));

// ==== tb/txrxf_mac_model.sv ====
// Behavioural MAC partner draining the transmit side
`timescale 1ns/100ps
module txrxf_mac_model (
    input  wire        core_clk_in,
    input  wire        resetn_in,
    input  wire [31:0] data_in,
    input  wire        valid_in,
    input  wire        last_in,
    input  wire        slow_in,
    input  wire        coll_req_in,
    output reg         ready_out,
    output reg         ok_out,
    output reg         coll_out
);
    int        frames, nw, cyc;
    bit        hit;
    reg [31:0] cur_q[$], got_q[$];
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ready_out <= 1'b0; ok_out <= 1'b0; coll_out <= 1'b0;
            frames = 0; nw = 0; cyc = 0; hit = 0; cur_q = {}; got_q = {};
        end else begin
            cyc++;
            ok_out <= 1'b0;
            coll_out <= 1'b0;
            ready_out <= !slow_in || (cyc % 4 == 0);
            if (!coll_req_in) hit = 0;
            if (valid_in && ready_out) begin
                cur_q.push_back(data_in);
                nw++;
                // One collision per request, words so far are thrown away
                if (coll_req_in && !hit && nw == 4) begin
                    coll_out <= 1'b1; hit = 1; nw = 0; cur_q = {};
                    // Take nothing while the block flushes, or a stale word joins the replay
                    ready_out <= 1'b0;
                end else if (last_in) begin
                    while (cur_q.size()) got_q.push_back(cur_q.pop_front());
                    frames++; nw = 0; ok_out <= 1'b1;
                end
            end
        end
    end
endmodule // txrxf_mac_model

// ==== tb/tx_rx_fifo_early_release_bench.sv ====
// Self-checking bench for the frame FIFO subsystem
`timescale 1ns/100ps
module tx_rx_fifo_early_release_bench;
    reg clk = 0, rstn = 0, er = 0, pre = 0, prd = 0, hpv = 0, lpv = 0, tv = 0, tl = 0;
    reg rv = 0, rl = 0, rdy = 0, slow = 0, creq = 0;
    reg [31:0] hpa = 0, td = 0, rd = 0, seed = 32'h60768cea, rs = 32'h60768cea;
    wire [31:0] ptr, mtd, rxd;
    wire [11:0] free;
    reg [11:0] thr = 12'h200;
    wire fok, hpt, lpt, trdy, mtv, mtl, mrdy, col, ok, rxv, rxl;
    int errors = 0, n_checks = 0, i, lpn = 0, hpn = 0;
    reg [31:0] exq[$], rxq[$];
    txrxf_top txrxf_top_inst (
        .core_clk_in(clk), .resetn_in(rstn), .early_release_en_in(er),
        .tx_threshold_in(thr), .preemptive_queue_in(pre),
        .hp_cmd_addr_in(hpa), .hp_cmd_valid_in(hpv), .lp_cmd_addr_in(32'h0),
        .lp_cmd_valid_in(lpv), .cmd_ptr_rd_in(prd), .cmd_ptr_out(ptr),
        .hp_fetch_ok_out(fok), .hp_cmd_take_out(hpt), .lp_cmd_take_out(lpt),
        .txf_data_in(td), .txf_valid_in(tv), .txf_last_in(tl), .txf_csum_done_in(tl),
        .txf_ready_out(trdy), .tx_free_bytes_out(free), .mac_tx_data_out(mtd),
        .mac_tx_valid_out(mtv), .mac_tx_last_out(mtl), .mac_tx_ready_in(mrdy),
        .mac_collision_in(col), .mac_underrun_in(1'b0), .mac_tx_ok_in(ok),
        .mac_rx_data_in(rd), .mac_rx_valid_in(rv), .mac_rx_last_in(rl),
        .rxd_data_out(rxd), .rxd_valid_out(rxv), .rxd_last_out(rxl), .rxd_ready_in(rdy));
    txrxf_mac_model txrxf_mac_model_inst (
        .core_clk_in(clk), .resetn_in(rstn), .data_in(mtd), .valid_in(mtv), .last_in(mtl),
        .slow_in(slow), .coll_req_in(creq), .ready_out(mrdy), .ok_out(ok), .coll_out(col));
    ////////////////////////////////////////
    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task chk(input [31:0] g, input [31:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task print_verdict;
        $display("errors=%0d checks=%0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task send(input int n);
        for (int k = 0; k < n; k++) begin
            @(negedge clk);
            seed = lfsr(seed); td = seed; tv = 1; tl = (k == n - 1);
            exq.push_back(seed);
            while (!trdy) @(negedge clk);
            @(posedge clk);
        end
        @(negedge clk); tv = 0; tl = 0;
    endtask
    task wait_f(input int n);
        while (txrxf_mac_model_inst.frames < n) @(negedge clk);
        while (exq.size()) chk(txrxf_mac_model_inst.got_q.pop_front(), exq.pop_front());
        repeat (4) @(negedge clk);
        $display("frame %0d done", n);
    endtask
    task rxf(input int n);
        for (int k = 0; k < n; k++) begin
            @(negedge clk); seed = lfsr(seed); rd = seed; rv = 1; rl = (k == n - 1);
            if (n >= 16) rxq.push_back(seed);
        end
        @(negedge clk); rv = 0; rl = 0;
    endtask
    ////////////////////////////////////////
    initial forever #5 clk = ~clk;
    // Receiver stalls at random to exercise the output buffer
    always @(negedge clk) begin rs = lfsr(rs); rdy = rs[0] | rs[1]; end
    always @(posedge clk) if (rxv && rdy) chk(rxd, rxq.size() ? rxq.pop_front() : 32'hx);
    always @(posedge clk) begin lpn += lpt; hpn += hpt; end
    initial begin #200000; errors++; print_verdict; end
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk); rstn = 1;
        chk(free, 12'hc00);
        chk({trdy, fok, mtv, rxv}, 4'b1100);
        send(20); send(20); wait_f(2);
        chk(free, 12'hc00);
        creq = 1; send(20); wait_f(3); creq = 0;
        slow = 1;
        for (i = 0; i < 3; i++) begin
            er = (i != 1); pre = (i == 2);
            send(40);
            while (txrxf_mac_model_inst.nw < 36) @(negedge clk);
            chk(free, i == 0 ? 12'hc00 : 12'hc00 - 12'd160);
            wait_f(4 + i);
        end
        slow = 0; er = 0; pre = 0;
        // Low threshold: sending must begin before the whole frame is written
        repeat (100) @(negedge clk);
        thr = 12'h040;
        send(40);
        chk(mtv, 1);
        wait_f(7);
        thr = 12'h200;
        rxf(8); rxf(20); repeat (80) @(negedge clk);
        chk(rxq.size(), 0);
        $display("receive test done");
        @(negedge clk); seed = lfsr(seed); hpa = seed; prd = 1;
        @(negedge clk); prd = 0;
        chk(ptr, hpa);
        chk(fok, 0);
        lpv = 1; repeat (10) @(negedge clk); lpv = 0;
        chk(lpn != 0, 1);
        hpv = 1; repeat (10) @(negedge clk); hpv = 0;
        chk(hpn != 0, 1);
        $display("queue test done");
        print_verdict;
    end
endmodule // tx_rx_fifo_early_release_bench
